// ==== sim/code_mem_model.sv ====
// Behavioural external code and data memory.
// Assumes the port's pin struct with active-low strobes.
`timescale 1ns/1ps
module code_mem_model
	import ext_code_memory_port_pkg::*;
(
	// Clock
	input  wire logic      clk_i,
	// Pins from the port
	input  wire mem_pins_s pins_i,
	input  wire logic      ce_n_i,
	output logic [7:0]     bus_o
);
	logic [7:0] mem [256];
	logic [7:0] last_reg;
	logic [7:0] idx;
	logic       rd, wr;
	// Code strobes count only while the chip is enabled
	assign rd = !pins_i.xbus_read_strobe_n || (!pins_i.code_read_strobe_n && !ce_n_i);
	assign wr = !pins_i.xbus_write_strobe_n || (!pins_i.code_write_strobe_n && !ce_n_i);
	assign idx = {!(pins_i.xbus_read_strobe_n && pins_i.xbus_write_strobe_n), pins_i.addr[6:0]};
	initial last_reg = 8'h00;
	always_comb begin
		if (rd) bus_o = mem[idx];
		else if (pins_i.data_oe) bus_o = pins_i.data_out;
		else if (pins_i.pullup_en) bus_o = 8'hFF;
		// Floating bus toggles so a stale byte never passes
		else bus_o = ~last_reg;
	end
	always @(posedge clk_i) begin
		last_reg <= bus_o;
		if (wr) mem[idx] <= bus_o;
	end
endmodule

// ==== sim/ext_code_memory_port_properties.sv ====
// Pin assertions for the code and data port.
// Bound to the port; sees only its ports.
`timescale 1ns/1ps
module ext_code_memory_port_properties
	import ext_code_memory_port_pkg::*;
(
	// Clock and reset
	input wire logic      clk_i,
	input wire logic      reset_i,
	// Pins
	input wire mem_pins_s mem_pins_o,
	input wire logic      code_chip_enable_n_o,
	input wire logic      ext_wake_interrupt_i
);
	mem_pins_s p;
	logic      any_low;
	assign p = mem_pins_o;
	assign any_low = !(p.code_read_strobe_n && p.code_write_strobe_n
		&& p.xbus_read_strobe_n && p.xbus_write_strobe_n);
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	property p_no_overlap;
		(p.code_read_strobe_n || p.code_write_strobe_n)
			&& (p.xbus_read_strobe_n || p.xbus_write_strobe_n);
	endproperty
	a_no_overlap: assert property (p_no_overlap) else $error("strobes overlap");
	property p_rd_no_drive;
		!(p.code_read_strobe_n && p.xbus_read_strobe_n) |-> !p.data_oe;
	endproperty
	a_rd_no_drive: assert property (p_rd_no_drive) else $error("bus driven in read");
	property p_code_strap;
		$fell(p.code_read_strobe_n) || $fell(p.code_write_strobe_n) |-> !p.pullup_en;
	endproperty
	a_code_strap: assert property (p_code_strap) else $error("code access with pull-ups");
	property p_code_wr;
		$fell(p.code_write_strobe_n) |-> p.data_oe
			##0 (!p.code_write_strobe_n)[*6] ##1 p.code_write_strobe_n;
	endproperty
	a_code_wr: assert property (p_code_wr) else $error("code write strobe shape");
	property p_code_rd;
		$fell(p.code_read_strobe_n) |-> (!p.code_read_strobe_n)[*6] ##1 p.code_read_strobe_n;
	endproperty
	a_code_rd: assert property (p_code_rd) else $error("code read strobe shape");
	property p_xbus_rd;
		$fell(p.xbus_read_strobe_n) |-> (!p.xbus_read_strobe_n)[*6] ##1 p.xbus_read_strobe_n;
	endproperty
	a_xbus_rd: assert property (p_xbus_rd) else $error("data read strobe shape");
	property p_xbus_wr;
		$fell(p.xbus_write_strobe_n) |-> p.data_oe
			##0 (!p.xbus_write_strobe_n)[*6] ##1 p.xbus_write_strobe_n;
	endproperty
	a_xbus_wr: assert property (p_xbus_wr) else $error("data write strobe shape");
	property p_addr_hold;
		$rose(any_low) |-> $stable(p.addr)[*6];
	endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("address moved in strobe");
	property p_wake_enable;
		ext_wake_interrupt_i[*8] |-> !code_chip_enable_n_o;
	endproperty
	a_wake_enable: assert property (p_wake_enable) else $error("chip off during wake");
endmodule
bind ext_code_memory_port ext_code_memory_port_properties u_props (
	.clk_i(clk_i), .reset_i(reset_i), .mem_pins_o(mem_pins_o),
	.code_chip_enable_n_o(code_chip_enable_n_o), .ext_wake_interrupt_i(ext_wake_interrupt_i));

// ==== sim/tb_ext_code_memory_port.sv ====
// Bench for the code and data port.
// Assumes the memory model on the pins and AXI4-Lite access.
`timescale 1ns/1ps
module tb_ext_code_memory_port import ext_code_memory_port_pkg::*;;
	logic        clk_i, reset_i, aw_valid, w_valid, b_ready, ar_valid, r_ready;
	logic        aw_ready, w_ready, b_valid, ar_ready, r_valid, ce_n, strap, wake, card_n;
	logic [7:0]  aw_addr, ar_addr, bus;
	logic [31:0] w_data, r_data, st;
	logic [1:0]  b_resp, r_resp, resp;
	mem_pins_s   pins;
	int          n_mismatch, check_count, cyc;
	ext_code_memory_port dut (.clk_i(clk_i), .reset_i(reset_i),
		.s_axi_awaddr_i(aw_addr), .s_axi_awvalid_i(aw_valid), .s_axi_awready_o(aw_ready),
		.s_axi_wdata_i(w_data), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(w_valid),
		.s_axi_wready_o(w_ready), .s_axi_bresp_o(b_resp), .s_axi_bvalid_o(b_valid),
		.s_axi_bready_i(b_ready), .s_axi_araddr_i(ar_addr), .s_axi_arvalid_i(ar_valid),
		.s_axi_arready_o(ar_ready), .s_axi_rdata_o(r_data), .s_axi_rresp_o(r_resp),
		.s_axi_rvalid_o(r_valid), .s_axi_rready_i(r_ready), .mem_pins_o(pins),
		.mem_data_bus_i(bus), .code_chip_enable_n_o(ce_n), .internal_code_select_i(strap),
		.ext_wake_interrupt_i(wake), .card_present_n_i(card_n));
	code_mem_model mem (.clk_i(clk_i), .pins_i(pins), .ce_n_i(ce_n), .bus_o(bus));
	always #12.5 clk_i = ~clk_i;
	task automatic end_of_test();
		if (n_mismatch == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Whole run is well under a thousand cycles
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 5000) begin
			n_mismatch++;
			end_of_test();
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("FAIL %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		aw_addr <= a;
		w_data <= d;
		aw_valid <= 1'b1;
		w_valid <= 1'b1;
		b_ready <= 1'b1;
		do begin
			@(posedge clk_i);
			if (aw_ready) aw_valid <= 1'b0;
			if (w_ready) w_valid <= 1'b0;
		end while (b_valid !== 1'b1);
		resp = b_resp;
		b_ready <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [7:0] a);
		ar_addr <= a;
		ar_valid <= 1'b1;
		r_ready <= 1'b1;
		do begin
			@(posedge clk_i);
			if (ar_ready) ar_valid <= 1'b0;
		end while (r_valid !== 1'b1);
		st = r_data;
		resp = r_resp;
		r_ready <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic cmd(input logic [15:0] a, input logic [7:0] d, input access_cmd_e c);
		wr(ACCESS_ADDR_OFFSET, {16'h0000, a});
		wr(ACCESS_DATA_OFFSET, {24'h000000, d});
		wr(ACCESS_CMD_OFFSET, {30'h0, c});
		do rd(ACCESS_STATUS_OFFSET); while (st[BUSY_BIT] !== 1'b0);
	endtask
	initial begin
		clk_i = 1'b0;
		reset_i = 1'b1;
		{aw_valid, w_valid, b_ready, ar_valid, r_ready, strap, wake, card_n} = '0;
		{aw_addr, ar_addr, w_data} = '0;
		{n_mismatch, check_count, cyc} = '0;
		repeat (3) @(posedge clk_i);
		reset_i <= 1'b0;
		// The captured strap settles two edges after release
		repeat (2) @(posedge clk_i);
		rd(GPIO_INPUT_OFFSET);
		chk(st, 32'h00000000);
		chk(32'({pins.pullup_en, pins.data_oe}), 32'h00000000);
		rd(ACCESS_STATUS_OFFSET);
		chk(st, 32'h00010000);
		cmd(16'h0012, 8'hA5, CMD_CODE_WRITE);
		cmd(16'hC012, 8'h5A, CMD_XBUS_WRITE);
		cmd(16'hC012, 8'h00, CMD_XBUS_READ);
		chk(32'(st[15:0]), 32'h00005A00);
		chk(32'(pins.addr), 32'h0000C012);
		cmd(16'h0012, 8'h00, CMD_CODE_READ);
		chk(32'(st[15:0]), 32'h0000A500);
		wr(8'h1C, 32'h1);
		chk(32'(resp), 32'(RESP_SLVERR));
		rd(8'h1C);
		chk({resp, st[29:0]}, {RESP_SLVERR, 30'h0});
		wr(POWER_CONTROL_OFFSET, 32'h1);
		wr(CLOCK_SELECT_OFFSET, 32'h1);
		chk(32'(ce_n), 32'h00000001);
		wake <= 1'b1;
		repeat (8) @(posedge clk_i);
		chk(32'(ce_n), 32'h00000000);
		wake <= 1'b0;
		repeat (8) @(posedge clk_i);
		chk(32'(ce_n), 32'h00000001);
		wr(CLOCK_SELECT_OFFSET, 32'h0);
		chk(32'(ce_n), 32'h00000000);
		wr(CLOCK_SELECT_OFFSET, 32'h1);
		wr(POWER_CONTROL_OFFSET, 32'h0);
		chk(32'(ce_n), 32'h00000000);
		strap <= 1'b1;
		card_n <= 1'b1;
		reset_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		reset_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rd(GPIO_INPUT_OFFSET);
		chk(st, 32'h00000003);
		chk(32'({pins.pullup_en, bus}), 32'h000001FF);
		cmd(16'h0012, 8'h00, CMD_CODE_READ);
		chk(32'({st[16], st[1:0]}), 32'h00000002);
		end_of_test();
	end
endmodule

// ==== verilog/ext_code_memory_port.sv ====
// External program-memory and external data-space port with AXI4-Lite registers.
// Assumes an external flash, SRAM or EPROM on the pins and software on the bus.
//
// How it works
// - Strap 0: data bus carries code data
// - Strap 1: weak pull-ups hold data bus
// - Drive 16-bit memory address bus
// - Code write strobe low only during writes
// - Code read strobe low only during reads
// - Chip enable high when idle, no wake, sleep
// - Chip enable low once any condition drops
// - Data-space read strobe low per read
// - Data-space write strobe low per write
// - Sample card detect, low means present
// - Capture strap at reset release, readable
`timescale 1ns/1ps
module ext_code_memory_port
	import ext_code_memory_port_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	// AXI4-Lite write address and data
	input  wire logic [7:0]  s_axi_awaddr_i,
	input  wire logic        s_axi_awvalid_i,
	output logic             s_axi_awready_o,
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	input  wire logic        s_axi_wvalid_i,
	output logic             s_axi_wready_o,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp_o,
	output logic             s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	// AXI4-Lite read
	input  wire logic [7:0]  s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	output logic             s_axi_arready_o,
	output logic [31:0]      s_axi_rdata_o,
	output logic [1:0]       s_axi_rresp_o,
	output logic             s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	// Memory pins
	output mem_pins_s        mem_pins_o,
	input  wire logic [7:0]  mem_data_bus_i,
	output logic             code_chip_enable_n_o,
	// Other pins
	input  wire logic        internal_code_select_i,
	input  wire logic        ext_wake_interrupt_i,
	input  wire logic        card_present_n_i
);

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SETUP,
		ST_STROBE,
		ST_HOLD
	} access_state_e;

	function automatic logic is_write_cmd(input access_cmd_e cmd);
		return (cmd == CMD_CODE_WRITE) || (cmd == CMD_XBUS_WRITE);
	endfunction

	function automatic logic is_code_cmd(input access_cmd_e cmd);
		return (cmd == CMD_CODE_READ) || (cmd == CMD_CODE_WRITE);
	endfunction

	// Conditioned pins: strap, wake, card detect, data bus
	logic [10:0] pins_raw;
	logic [10:0] pins_level;
	logic        strap_level;
	logic        wake_level;
	logic        card_n_level;
	logic [7:0]  data_level;

	assign pins_raw = {mem_data_bus_i, card_present_n_i, ext_wake_interrupt_i,
		internal_code_select_i};

	pin_sync3 #(
		.WIDTH(11)
	) u_pin_sync (
		.clk_i        (clk_i),
		.reset_i      (reset_i),
		.pin_i        (pins_raw),
		.reset_level_i(11'h7FF),
		.level_o      (pins_level)
	);

	assign strap_level  = pins_level[0];
	assign wake_level   = pins_level[1];
	assign card_n_level = pins_level[2];
	assign data_level   = pins_level[10:3];

	// Software state
	logic        idle_reg;
	logic        sleep_reg;
	logic [15:0] addr_reg;
	logic [7:0]  wdata_reg;
	logic [7:0]  rdata_reg;
	logic        refused_reg;
	logic        code_select_reg;
	logic [1:0]  strap_step_reg;
	logic        card_present_reg;

	// Access engine
	access_state_e            state_reg;
	access_cmd_e              cmd_reg;
	logic [STROBE_CNT_W-1:0]  count_reg;
	logic                     start_req;
	access_cmd_e              start_cmd;

	// Write channel bookkeeping
	logic        aw_held_reg;
	logic        w_held_reg;
	logic [7:0]  waddr_reg;
	logic [31:0] wdata_bus_reg;
	logic [3:0]  wstrb_reg;
	logic        aw_now;
	logic        w_now;
	logic        wr_fire;
	logic [7:0]  wr_addr;
	logic [31:0] wr_data;
	logic [3:0]  wr_strb;

	assign aw_now  = s_axi_awvalid_i && s_axi_awready_o;
	assign w_now   = s_axi_wvalid_i && s_axi_wready_o;
	assign wr_fire = (aw_held_reg || aw_now) && (w_held_reg || w_now) && !s_axi_bvalid_o;
	assign wr_addr = aw_held_reg ? waddr_reg : s_axi_awaddr_i;
	assign wr_data = w_held_reg ? wdata_bus_reg : s_axi_wdata_i;
	assign wr_strb = w_held_reg ? wstrb_reg : s_axi_wstrb_i;

	// Address and data are accepted in either order and held until paired
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			aw_held_reg     <= 1'b0;
			w_held_reg      <= 1'b0;
			waddr_reg       <= 8'h00;
			wdata_bus_reg   <= 32'h00000000;
			wstrb_reg       <= 4'h0;
			s_axi_awready_o <= 1'b0;
			s_axi_wready_o  <= 1'b0;
		end else begin
			if (wr_fire) begin
				aw_held_reg <= 1'b0;
				w_held_reg  <= 1'b0;
			end else begin
				if (aw_now) begin
					aw_held_reg <= 1'b1;
					waddr_reg   <= s_axi_awaddr_i;
				end
				if (w_now) begin
					w_held_reg    <= 1'b1;
					wdata_bus_reg <= s_axi_wdata_i;
					wstrb_reg     <= s_axi_wstrb_i;
				end
			end
			s_axi_awready_o <= !aw_held_reg && !aw_now && !s_axi_bvalid_o && !wr_fire;
			s_axi_wready_o  <= !w_held_reg && !w_now && !s_axi_bvalid_o && !wr_fire;
		end
	end

	// Write response and register updates
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o  <= RESP_OKAY;
			idle_reg       <= 1'b0;
			sleep_reg      <= 1'b0;
			addr_reg       <= ADDR_RESET;
			wdata_reg      <= DATA_RESET;
		end else begin
			if (s_axi_bvalid_o && s_axi_bready_i) begin
				s_axi_bvalid_o <= 1'b0;
			end
			if (wr_fire) begin
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o  <= RESP_OKAY;
				unique case (wr_addr)
					POWER_CONTROL_OFFSET: if (wr_strb[0]) idle_reg <= wr_data[IDLE_BIT];
					CLOCK_SELECT_OFFSET:  if (wr_strb[0]) sleep_reg <= wr_data[SLEEP_BIT];
					ACCESS_ADDR_OFFSET: begin
						if (wr_strb[0]) addr_reg[7:0] <= wr_data[7:0];
						if (wr_strb[1]) addr_reg[15:8] <= wr_data[15:8];
					end
					ACCESS_DATA_OFFSET:   if (wr_strb[0]) wdata_reg <= wr_data[7:0];
					ACCESS_CMD_OFFSET,
					ACCESS_STATUS_OFFSET,
					GPIO_INPUT_OFFSET: begin
					end
					default: s_axi_bresp_o <= RESP_SLVERR;
				endcase
			end
		end
	end

	// A command write starts one access; extra commands while busy are dropped
	assign start_req = wr_fire && (wr_addr == ACCESS_CMD_OFFSET) && wr_strb[0];
	assign start_cmd = access_cmd_e'(wr_data[1:0]);

	// Access sequence: setup, strobe, hold; one strobe at a time
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			state_reg   <= ST_IDLE;
			cmd_reg     <= CMD_CODE_READ;
			count_reg   <= '0;
			refused_reg <= 1'b0;
			rdata_reg   <= DATA_RESET;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					if (start_req) begin
						// Code space exists only with an external memory fitted
						if (is_code_cmd(start_cmd) && code_select_reg) begin
							refused_reg <= 1'b1;
						end else begin
							refused_reg <= 1'b0;
							cmd_reg     <= start_cmd;
							state_reg   <= ST_SETUP;
						end
					end
				end
				ST_SETUP: begin
					count_reg <= STROBE_CNT_W'(STROBE_CYCLES - 1);
					state_reg <= ST_STROBE;
				end
				ST_STROBE: begin
					if (count_reg == '0) begin
						// Strobe is long enough for the data to clear the input flops
						if (!is_write_cmd(cmd_reg)) begin
							rdata_reg <= data_level;
						end
						state_reg <= ST_HOLD;
					end else begin
						count_reg <= count_reg - 1'b1;
					end
				end
				ST_HOLD: state_reg <= ST_IDLE;
			endcase
		end
	end

	// Pin drive; strobes only inside the strobe phase, bus held through hold
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			mem_pins_o.addr                <= ADDR_RESET;
			mem_pins_o.data_out            <= DATA_RESET;
			mem_pins_o.data_oe             <= 1'b0;
			mem_pins_o.pullup_en           <= 1'b1;
			mem_pins_o.code_read_strobe_n  <= 1'b1;
			mem_pins_o.code_write_strobe_n <= 1'b1;
			mem_pins_o.xbus_read_strobe_n  <= 1'b1;
			mem_pins_o.xbus_write_strobe_n <= 1'b1;
		end else begin
			mem_pins_o.addr      <= addr_reg;
			mem_pins_o.data_out  <= wdata_reg;
			mem_pins_o.pullup_en <= code_select_reg;
			mem_pins_o.data_oe   <= (state_reg != ST_IDLE) && is_write_cmd(cmd_reg);
			mem_pins_o.code_read_strobe_n  <=
				!((state_reg == ST_STROBE) && (cmd_reg == CMD_CODE_READ));
			mem_pins_o.code_write_strobe_n <=
				!((state_reg == ST_STROBE) && (cmd_reg == CMD_CODE_WRITE));
			mem_pins_o.xbus_read_strobe_n  <=
				!((state_reg == ST_STROBE) && (cmd_reg == CMD_XBUS_READ));
			mem_pins_o.xbus_write_strobe_n <=
				!((state_reg == ST_STROBE) && (cmd_reg == CMD_XBUS_WRITE));
		end
	end

	// Chip enable gated off only in combined idle and sleep with no wake request
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			code_chip_enable_n_o <= 1'b0;
		end else begin
			code_chip_enable_n_o <= idle_reg && !wake_level && sleep_reg;
		end
	end

	// Pin flops show their reset level for one edge, so the strap is taken at the second
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			strap_step_reg  <= 2'b00;
			code_select_reg <= 1'b1;
		end else if (strap_step_reg != 2'b10) begin
			strap_step_reg  <= strap_step_reg + 2'b01;
			code_select_reg <= strap_level;
		end
	end

	// Card presence from the pulled-up, active-low detect pin
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			card_present_reg <= 1'b0;
		end else begin
			card_present_reg <= !card_n_level;
		end
	end

	// Read channel: one read under way, answered the cycle after it is taken
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o  <= 1'b0;
			s_axi_rdata_o   <= 32'h00000000;
			s_axi_rresp_o   <= RESP_OKAY;
		end else begin
			if (s_axi_rvalid_o && s_axi_rready_i) begin
				s_axi_rvalid_o <= 1'b0;
			end
			s_axi_arready_o <= !s_axi_rvalid_o && !(s_axi_arvalid_i && s_axi_arready_o);
			if (s_axi_arvalid_i && s_axi_arready_o) begin
				s_axi_rvalid_o <= 1'b1;
				s_axi_rresp_o  <= RESP_OKAY;
				s_axi_rdata_o  <= 32'h00000000;
				unique case (s_axi_araddr_i)
					POWER_CONTROL_OFFSET: s_axi_rdata_o[IDLE_BIT] <= idle_reg;
					CLOCK_SELECT_OFFSET:  s_axi_rdata_o[SLEEP_BIT] <= sleep_reg;
					ACCESS_ADDR_OFFSET:   s_axi_rdata_o[15:0] <= addr_reg;
					ACCESS_DATA_OFFSET:   s_axi_rdata_o[7:0] <= wdata_reg;
					ACCESS_CMD_OFFSET:    s_axi_rdata_o[1:0] <= cmd_reg;
					ACCESS_STATUS_OFFSET: begin
						s_axi_rdata_o[BUSY_BIT]         <= (state_reg != ST_IDLE);
						s_axi_rdata_o[REFUSED_BIT]      <= refused_reg;
						s_axi_rdata_o[RDATA_LSB +: 8]   <= rdata_reg;
						s_axi_rdata_o[CARD_PRESENT_BIT] <= card_present_reg;
					end
					GPIO_INPUT_OFFSET: begin
						s_axi_rdata_o[CODE_SELECT_BIT] <= code_select_reg;
						s_axi_rdata_o[CARD_PIN_BIT]    <= card_n_level;
					end
					default: s_axi_rresp_o <= RESP_SLVERR;
				endcase
			end
		end
	end

endmodule

// ==== verilog/ext_code_memory_port_pkg.sv ====
// Package for the external program-memory and data-space port.
// Assumes one 40 MHz clock and a 32-bit AXI4-Lite register bus.
package ext_code_memory_port_pkg;

	// Clock and access timing
	localparam int CLK_PERIOD_PS   = 25000;
	localparam int STROBE_TIME_NS  = 150;
	localparam int STROBE_CYCLES   = (STROBE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int STROBE_CNT_W    = 4;

	// Register byte offsets
	localparam logic [7:0] POWER_CONTROL_OFFSET = 8'h00;
	localparam logic [7:0] CLOCK_SELECT_OFFSET  = 8'h04;
	localparam logic [7:0] ACCESS_ADDR_OFFSET   = 8'h08;
	localparam logic [7:0] ACCESS_DATA_OFFSET   = 8'h0C;
	localparam logic [7:0] ACCESS_CMD_OFFSET    = 8'h10;
	localparam logic [7:0] ACCESS_STATUS_OFFSET = 8'h14;
	localparam logic [7:0] GPIO_INPUT_OFFSET    = 8'h18;

	// Field positions
	localparam int IDLE_BIT        = 0;
	localparam int SLEEP_BIT       = 0;
	localparam int BUSY_BIT        = 0;
	localparam int REFUSED_BIT     = 1;
	localparam int RDATA_LSB       = 8;
	localparam int CARD_PRESENT_BIT = 16;
	localparam int CODE_SELECT_BIT = 0;
	localparam int CARD_PIN_BIT    = 1;

	// Reset values
	localparam logic [15:0] ADDR_RESET  = 16'h0000;
	localparam logic [7:0]  DATA_RESET  = 8'h00;

	// AXI4-Lite responses
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [1:0] {
		CMD_CODE_READ,
		CMD_CODE_WRITE,
		CMD_XBUS_READ,
		CMD_XBUS_WRITE
	} access_cmd_e;

	// Memory pins, all driven from flip-flops
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  data_out;
		logic        data_oe;
		logic        pullup_en;
		logic        code_read_strobe_n;
		logic        code_write_strobe_n;
		logic        xbus_read_strobe_n;
		logic        xbus_write_strobe_n;
	} mem_pins_s;

endpackage

// ==== verilog/pin_sync3.sv ====
// Three-flop input conditioner for pins from outside the clock domain.
// A change is taken once the second and third flops agree.
`timescale 1ns/1ps
module pin_sync3
	import ext_code_memory_port_pkg::*;
#(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             reset_i,
	// Raw and settled levels
	input  wire logic [WIDTH-1:0] pin_i,
	input  wire logic [WIDTH-1:0] reset_level_i,
	output logic      [WIDTH-1:0] level_o
);

	logic [WIDTH-1:0] stage1_reg;
	logic [WIDTH-1:0] stage2_reg;
	logic [WIDTH-1:0] stage3_reg;

	always_ff @(posedge clk_i) begin
		stage1_reg <= pin_i;
		stage2_reg <= stage1_reg;
		stage3_reg <= stage2_reg;
	end

	// Per-bit agreement check, so a bit glitching alone never moves the output
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			always_ff @(posedge clk_i) begin
				if (reset_i) begin
					level_o[g] <= reset_level_i[g];
				end else if (stage2_reg[g] == stage3_reg[g]) begin
					level_o[g] <= stage3_reg[g];
				end
			end
		end
	endgenerate

endmodule
